// ==== include/hbd_defines.vh ====
`ifndef HBD_DEFINES_VH
`define HBD_DEFINES_VH

// Register offsets (8-bit address space)
`define HBD_ADR_IST0 8'h00
`define HBD_ADR_IST1 8'h01
`define HBD_ADR_IST2 8'h02
`define HBD_ADR_IMSK0 8'h04
`define HBD_ADR_IMSK1 8'h05
`define HBD_ADR_IMSK2 8'h06
`define HBD_ADR_TXCNT_LO 8'h08
`define HBD_ADR_TXCNT_HI 8'h09
`define HBD_ADR_STAT 8'h0A

// Reset values
`define HBD_MASK_RST 8'hFF
`define HBD_ZERO8 8'h00
`define HBD_ZERO16 16'h0000
`define HBD_ZERO6 6'h00
`define HBD_ZERO5 5'h00
`define HBD_ZERO24 24'h000000
`define HBD_ONES8 8'hFF

// Transmit DMA block size in bytes
`define HBD_BLOCK 6'h20
`define HBD_ONE16 16'h0001
`define HBD_ONE6 6'h01
`define HBD_TWO16 16'h0002
`define HBD_TWO6 6'h02

// Access state machine, one-hot
`define HBD_S_IDLE 3'h1
`define HBD_S_ACK 3'h2
`define HBD_S_DONE 3'h4

`endif

// ==== rtl/hbd_host_port.v ====
// How it works
// (RULE1) Host holds write data valid while write strobe stays low.
// (RULE2) Width input low selects 8-bit bus; high selects 16-bit word transfers.
// (RULE3) In 16-bit mode lane enables or lane strobes pick the bytes; count low writes take the low byte even with only the high lane on.
// (RULE4) Interrupt request goes active when any status bit is set; the code counts only status bits whose mask bit is zero.
// (RULE5) Reading a status register clears the bits it reports.
// (RULE6) Interrupt request inactive while all status bits are clear.
// (RULE7) A source reaches the request only when its mask bit is zero.
// (RULE8) Ready is asserted once the device can complete the transfer.
// (RULE9) Ready holds until the strobes or chip select go inactive.
// (RULE10) Ready is high impedance when no access is in progress.
// (RULE11) Low reset forces all registers and state machines to reset state.
// (RULE12) While reset is low every output is released.
// (RULE13) Transmit DMA request stays active while transmit FIFO needs data.
// (RULE14) Host writes byte count low and high before a transmit DMA.
// (RULE15) Transmit data is requested in 32-byte blocks plus a final rest.
// (RULE16) Transmit request drops at the start of the last write cycle.
// (RULE17) Receive DMA request stays active while receive FIFO needs emptying.
// (RULE18) Receive request drops right after the last read cycle begins.
// (RULE19) Low DMA grant with a strobe is the access enable for the FIFOs.
// (RULE20) During grant, address and chip select are ignored; FIFOs are selected.
// (RULE21) Bus style pin: high single-strobe, low strobe-pair, falling edge muxed.
// (RULE22) Host drives chip select low for any register access.
// (RULE23) In strobe-pair mode read data is driven while read strobe is low.
`timescale 1ns/10ps
`include "hbd_defines.vh"

module hbd_host_port (
  // Clock and reset
  input wire ref_clk,
  input wire reset_n,
  // Bus configuration
  input wire bus_width_16,
  input wire bus_style_select,
  // Host bus
  input wire chip_sel_n,
  input wire [7:0] addr,
  input wire rd_n,
  input wire wr_n,
  input wire transfer_strobe_n,
  input wire rd_wr_n,
  input wire low_lane_enable_n,
  input wire high_lane_enable_n,
  input wire low_lane_strobe_n,
  input wire high_lane_strobe_n,
  input wire [15:0] data_in,
  output reg [15:0] data_out,
  output wire data_oe,
  // Ready / acknowledge, active low, tri-state
  output wire transfer_ack_out_n,
  output wire transfer_ack_oe,
  // Interrupt, open drain, active low
  output wire irq_out_n,
  output wire irq_oe,
  // Interrupt event sources, one-cycle pulses
  input wire [23:0] irq_events,
  // Channel A DMA
  output wire tx_dma_request,
  output wire tx_dma_oe,
  output wire rx_dma_request,
  output wire rx_dma_oe,
  input wire dma_grant_n,
  // Transmit FIFO side
  input wire tx_dma_start,
  output reg [15:0] tx_fifo_data,
  output reg tx_fifo_wr,
  // Receive FIFO side
  input wire [15:0] rx_fifo_data,
  input wire [5:0] rx_block_bytes,
  input wire rx_block_ready,
  output reg rx_fifo_rd
);

  // ------------------------------------------------------------
  // Bus mode decode
  // ------------------------------------------------------------
  reg style_q_r;
  reg muxed_r;
  reg [7:0] latched_addr_r;

  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n) // RULE11
    begin
      style_q_r <= 1'b0;
      muxed_r <= 1'b0;
      latched_addr_r <= `HBD_ZERO8;
    end
    else
    begin
      style_q_r <= bus_style_select;
      // Falling edge selects multiplexed mode and latches the address
      if (style_q_r && !bus_style_select) // RULE21
      begin
        muxed_r <= 1'b1;
        latched_addr_r <= data_in[7:0];
      end
    end
  end

  // Single-strobe mode only when the pin sits static high
  wire single_strobe = bus_style_select && !muxed_r; // RULE21
  wire [7:0] eff_addr = muxed_r ? latched_addr_r : addr;

  wire lo_lane_raw = single_strobe ? !low_lane_strobe_n : !low_lane_enable_n;
  wire hi_lane_raw = single_strobe ? !high_lane_strobe_n : !high_lane_enable_n;
  wire lane_lo = bus_width_16 ? lo_lane_raw : 1'b1; // RULE2 RULE3
  wire lane_hi = bus_width_16 & hi_lane_raw; // RULE2 RULE3

  wire strobe_any = single_strobe ?
    (bus_width_16 ? (!low_lane_strobe_n || !high_lane_strobe_n) : !transfer_strobe_n) :
    (!rd_n || !wr_n);
  wire is_read = single_strobe ? rd_wr_n : !rd_n;
  wire dma_sel = !dma_grant_n && strobe_any; // RULE19 RULE20
  wire reg_sel = dma_grant_n && !chip_sel_n && strobe_any; // RULE20 RULE22
  wire acc = dma_sel || reg_sel;

  // ------------------------------------------------------------
  // Access state machine
  // ------------------------------------------------------------
  reg [2:0] state_r;
  reg [2:0] state_nxt;

  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      `HBD_S_IDLE: if (acc) state_nxt = `HBD_S_ACK; // RULE8
      `HBD_S_ACK: if (!acc) state_nxt = `HBD_S_IDLE; // RULE9
      `HBD_S_DONE: state_nxt = `HBD_S_IDLE;
      default: state_nxt = `HBD_S_IDLE;
    endcase
  end

  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      state_r <= `HBD_S_IDLE; // RULE11
    else
      state_r <= state_nxt;
  end

  wire start = (state_r == `HBD_S_IDLE) && acc;
  wire in_ack = (state_r == `HBD_S_ACK);
  assign transfer_ack_out_n = 1'b0;
  // Released outside an access and in reset so a shared pull-up wins
  assign transfer_ack_oe = in_ack && acc && reset_n; // RULE8 RULE9 RULE10 RULE12

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  reg [23:0] isr_r;
  reg [23:0] imr_r;
  reg [15:0] tx_count_r;
  reg [15:0] tx_left_r;
  reg [5:0] tx_blk_r;
  reg tx_active_r;
  reg [5:0] rx_left_r;
  reg rx_active_r;
  wire [23:0] irq_status_regs = isr_r;
  wire [23:0] irq_mask_regs = imr_r;

  function [7:0] lane_byte;
    input [15:0] d;
    input hi_only;
    begin
      lane_byte = hi_only ? d[15:8] : d[7:0];
    end
  endfunction

  wire hi_only = bus_width_16 && lane_hi && !lane_lo;
  wire [7:0] wbyte = lane_byte(data_in, hi_only);
  wire reg_wr = start && reg_sel && !is_read;
  wire reg_rd = start && reg_sel && is_read;
  wire dma_wr = start && dma_sel && !is_read;
  wire dma_rd = start && dma_sel && is_read;

  // Status clear on read, events set wins over the clear
  reg [23:0] rd_clr;
  always @*
  begin
    rd_clr = `HBD_ZERO24;
    // Whole byte clears at access start; the data latch takes the old value at that edge
    if (reg_rd)
      case (eff_addr)
        `HBD_ADR_IST0: rd_clr[7:0] = `HBD_ONES8; // RULE5
        `HBD_ADR_IST1: rd_clr[15:8] = `HBD_ONES8; // RULE5
        `HBD_ADR_IST2: rd_clr[23:16] = `HBD_ONES8; // RULE5
        default: rd_clr = `HBD_ZERO24;
      endcase
  end

  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      isr_r <= `HBD_ZERO24; // RULE11
      imr_r <= {`HBD_MASK_RST, `HBD_MASK_RST, `HBD_MASK_RST};
      tx_count_r <= `HBD_ZERO16;
    end
    else
    begin
      isr_r <= (isr_r & ~rd_clr) | irq_events;
      if (reg_wr)
        case (eff_addr)
          `HBD_ADR_IMSK0: imr_r[7:0] <= wbyte;
          `HBD_ADR_IMSK1: imr_r[15:8] <= wbyte;
          `HBD_ADR_IMSK2: imr_r[23:16] <= wbyte;
          `HBD_ADR_TXCNT_LO: // RULE14
          begin
            tx_count_r[7:0] <= data_in[7:0];
            if (bus_width_16 && lane_hi)
              tx_count_r[15:8] <= data_in[15:8];
          end
          `HBD_ADR_TXCNT_HI: tx_count_r[15:8] <= wbyte; // RULE14
          default: tx_count_r <= tx_count_r;
        endcase
    end
  end

  // Open-drain: pull low while any unmasked status bit is set
  // Status bits stay set while masked, so unmasking later still raises the request
  wire irq_pend = |(irq_status_regs & ~irq_mask_regs); // RULE4 RULE6 RULE7
  assign irq_out_n = 1'b0;
  assign irq_oe = irq_pend && reset_n; // RULE12

  // ------------------------------------------------------------
  // Transmit DMA
  // ------------------------------------------------------------
  // Bytes taken per cycle: two on a 16-bit word, else one
  wire [15:0] tx_step = (bus_width_16 && lane_lo && lane_hi) ? `HBD_TWO16 : `HBD_ONE16;
  wire [5:0] tx_step6 = (bus_width_16 && lane_lo && lane_hi) ? `HBD_TWO6 : `HBD_ONE6;
  // Last cycle of the whole count or of a 32-byte block
  wire tx_last = (tx_left_r <= tx_step) || (tx_blk_r <= tx_step6); // RULE15

  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_left_r <= `HBD_ZERO16;
      tx_blk_r <= `HBD_ZERO6;
      tx_active_r <= 1'b0;
      tx_fifo_data <= `HBD_ZERO16;
      tx_fifo_wr <= 1'b0;
    end
    else
    begin
      tx_fifo_wr <= dma_wr && tx_active_r;
      if (tx_dma_start && !tx_active_r &&
        (tx_left_r != `HBD_ZERO16 || tx_count_r != `HBD_ZERO16))
      begin
        // A restart after a full block resumes the bytes left, so the count is reached
        // Reloading here instead would repeat the first block for ever on long counts
        if (tx_left_r == `HBD_ZERO16)
          tx_left_r <= tx_count_r; // RULE15
        tx_blk_r <= `HBD_BLOCK; // RULE15
        tx_active_r <= 1'b1;
      end
      else if (dma_wr && tx_active_r)
      begin
        tx_fifo_data <= data_in;
        tx_left_r <= (tx_left_r <= tx_step) ? `HBD_ZERO16 : tx_left_r - tx_step;
        tx_blk_r <= (tx_blk_r <= tx_step6) ? `HBD_BLOCK : tx_blk_r - tx_step6;
        // FIFO refill restarts the next block via tx_dma_start
        if (tx_last)
          tx_active_r <= 1'b0;
      end
    end
  end

  // Drops combinationally as the final write strobe begins
  assign tx_dma_request = tx_active_r && !(dma_sel && !is_read && tx_last); // RULE13 RULE16
  assign tx_dma_oe = reset_n; // RULE12

  // ------------------------------------------------------------
  // Receive DMA
  // ------------------------------------------------------------
  wire rx_last = rx_left_r <= tx_step6;

  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_left_r <= `HBD_ZERO6;
      rx_active_r <= 1'b0;
      rx_fifo_rd <= 1'b0;
    end
    else
    begin
      rx_fifo_rd <= dma_rd && rx_active_r;
      if (rx_block_ready && !rx_active_r && rx_block_bytes != `HBD_ZERO6)
      begin
        rx_left_r <= rx_block_bytes; // RULE17
        rx_active_r <= 1'b1;
      end
      else if (dma_rd && rx_active_r)
      begin
        rx_left_r <= rx_last ? `HBD_ZERO6 : rx_left_r - tx_step6;
        if (rx_last)
          rx_active_r <= 1'b0; // RULE18
      end
    end
  end

  assign rx_dma_request = rx_active_r && !(dma_sel && is_read && rx_last); // RULE17 RULE18
  assign rx_dma_oe = reset_n; // RULE12

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  reg [7:0] rbyte;
  always @*
  begin
    case (eff_addr)
      `HBD_ADR_IST0: rbyte = isr_r[7:0];
      `HBD_ADR_IST1: rbyte = isr_r[15:8];
      `HBD_ADR_IST2: rbyte = isr_r[23:16];
      `HBD_ADR_IMSK0: rbyte = imr_r[7:0];
      `HBD_ADR_IMSK1: rbyte = imr_r[15:8];
      `HBD_ADR_IMSK2: rbyte = imr_r[23:16];
      `HBD_ADR_TXCNT_LO: rbyte = tx_count_r[7:0];
      `HBD_ADR_TXCNT_HI: rbyte = tx_count_r[15:8];
      `HBD_ADR_STAT: rbyte = {`HBD_ZERO5, muxed_r, tx_active_r, rx_active_r};
      default: rbyte = `HBD_ZERO8;
    endcase
  end

  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      data_out <= `HBD_ZERO16;
    else if (dma_rd)
      data_out <= rx_fifo_data;
    else if (reg_rd)
      data_out <= hi_only ? {rbyte, `HBD_ZERO8} : {`HBD_ZERO8, rbyte}; // RULE2
  end

  // Data lines driven only while the read strobe is held
  assign data_oe = in_ack && acc && is_read && reset_n; // RULE23 RULE12

endmodule // hbd_host_port

// ==== tb/hbd_props.sv ====
`timescale 1ns/10ps
module hbd_props (
  // Clock, reset and host strobes
  input wire ref_clk,
  input wire reset_n,
  input wire bus_style_select,
  input wire chip_sel_n,
  input wire rd_n,
  input wire wr_n,
  input wire dma_grant_n,
  input wire tx_dma_start,
  input wire [23:0] irq_events,
  // Device answers
  input wire data_oe,
  input wire transfer_ack_oe,
  input wire irq_oe,
  input wire tx_dma_request,
  input wire tx_dma_oe,
  input wire rx_dma_request,
  input wire rx_dma_oe,
  input wire tx_fifo_wr,
  input wire rx_fifo_rd
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  a_oe_in_reset:
    assert property (disable iff (1'b0) !reset_n |-> !(transfer_ack_oe || irq_oe || data_oe
      || tx_dma_oe || rx_dma_oe)) else $error("output enabled in reset");
  a_ack_answer:
    assert property ($fell(rd_n && wr_n) && !(chip_sel_n && dma_grant_n) && !bus_style_select
      |=> transfer_ack_oe) else $error("no ready after strobe");
  a_ack_holds:
    assert property ($past(transfer_ack_oe) && !(rd_n && wr_n) && !(chip_sel_n && dma_grant_n)
      && !bus_style_select |-> transfer_ack_oe) else $error("ready dropped early");
  a_read_drive:
    assert property (data_oe && !bus_style_select |-> !rd_n) else $error("data driven, no read");
  a_irq_cause:
    assert property ($rose(irq_oe) |-> $past(irq_events) != 24'h000000 || !$past(wr_n))
    else $error("interrupt without cause");
  a_tx_start:
    assert property (tx_dma_start |=> tx_dma_request) else $error("no tx request");
  a_tx_drop:
    assert property ($fell(tx_dma_request) |-> !dma_grant_n && !wr_n)
    else $error("tx request dropped outside write");
  a_rx_drop:
    assert property ($fell(rx_dma_request) |-> !dma_grant_n && !rd_n)
    else $error("rx request dropped outside read");
  a_fifo_write:
    assert property (tx_fifo_wr |-> !$past(dma_grant_n) && !$past(wr_n))
    else $error("fifo write without grant");
  a_fifo_read:
    assert property (rx_fifo_rd |-> !$past(dma_grant_n) && !$past(rd_n))
    else $error("fifo read without grant");
endmodule // hbd_props

bind hbd_host_port hbd_props u_props (.ref_clk, .reset_n, .bus_style_select, .chip_sel_n,
  .rd_n, .wr_n, .dma_grant_n, .tx_dma_start, .irq_events, .data_oe, .transfer_ack_oe,
  .irq_oe, .tx_dma_request, .tx_dma_oe, .rx_dma_request, .rx_dma_oe, .tx_fifo_wr, .rx_fifo_rd);

// ==== tb/hbd_host_model.sv ====
`timescale 1ns/10ps
module hbd_host_model (
  // Clock and device answers
  input wire ref_clk,
  input wire ack_pin_n,
  input wire [15:0] data_out,
  // Host CPU and DMA controller
  output reg chip_sel_n = 1'b1,
  output reg dma_grant_n = 1'b1,
  output reg rd_n = 1'b1,
  output reg wr_n = 1'b1,
  output reg [7:0] addr = 8'h00,
  output reg [15:0] data_in = 16'h0000,
  output reg [7:0] hangs = 8'h00
);
  // ----------------------------------------
  // One access, held until ready is seen low or a 16-cycle wait runs out
  // ----------------------------------------
  task access(input dma, input rd, input [7:0] a, input [15:0] d, output [15:0] q);
    integer n;
    begin
      n = 0;
      @(posedge ref_clk);
      chip_sel_n <= dma;
      dma_grant_n <= !dma;
      addr <= a;
      data_in <= d;
      rd_n <= !rd;
      wr_n <= rd;
      @(posedge ref_clk);
      while (ack_pin_n !== 1'b0 && n < 16)
      begin
        @(posedge ref_clk);
        n = n + 1;
      end
      if (n == 16)
        hangs <= hangs + 8'h01;
      q = data_out;
      chip_sel_n <= 1'b1;
      dma_grant_n <= 1'b1;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      // Released lines flip so a stale value cannot pass as fresh
      addr <= ~a;
      data_in <= ~d;
    end
  endtask
endmodule // hbd_host_model

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps
`include "hbd_defines.vh"
`define CHK(n, e, a) begin check_count = check_count + 1; if ((a) !== (e)) begin \
  miscompares = miscompares + 1; $display("BAD %s exp %h got %h", n, e, a); end end
module tb_top;
  reg ref_clk = 1'b0;
  reg reset_n = 1'b0;
  reg [23:0] irq_events = 24'h000000;
  reg tx_dma_start = 1'b0;
  reg rx_block_ready = 1'b0;
  reg [15:0] rx_fifo_data = 16'h0000;
  reg [5:0] rx_block_bytes = 6'h02;
  reg width16 = 1'b0;
  reg style = 1'b0;
  reg [1:0] lane_en_n = 2'b10;
  wire cs_n, gnt_n, rd_n, wr_n, ack_n, ack_oe, irq_n, irq_oe, data_oe, tx_req, tx_oe, rx_req;
  wire rx_oe, tx_wr, rx_rd;
  wire [7:0] addr, hangs;
  wire [15:0] data_in, data_out, tx_data;
  // Ready line has a pull-up on the board
  wire ack_pin_n = ack_oe ? ack_n : 1'b1;
  wire irq_pin_n = irq_oe ? irq_n : 1'b1;
  integer miscompares = 0;
  integer check_count = 0;
  integer cyc = 0;
  integer i, j;
  reg [15:0] q;
  always #10 ref_clk = ~ref_clk;
  // Spare strobes follow the active ones, except the high-lane strobe held high, as on a board in this mode
  hbd_host_port u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .bus_width_16(width16),
    .bus_style_select(style), .chip_sel_n(cs_n), .addr(addr), .rd_n(rd_n), .wr_n(wr_n),
    .transfer_strobe_n(rd_n & wr_n), .rd_wr_n(wr_n), .low_lane_enable_n(lane_en_n[0]),
    .high_lane_enable_n(lane_en_n[1]), .low_lane_strobe_n(rd_n & wr_n),
    .high_lane_strobe_n(1'b1),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .transfer_ack_out_n(ack_n),
    .transfer_ack_oe(ack_oe), .irq_out_n(irq_n), .irq_oe(irq_oe), .irq_events(irq_events),
    .tx_dma_request(tx_req), .tx_dma_oe(tx_oe), .rx_dma_request(rx_req), .rx_dma_oe(rx_oe),
    .dma_grant_n(gnt_n), .tx_dma_start(tx_dma_start), .tx_fifo_data(tx_data),
    .tx_fifo_wr(tx_wr), .rx_fifo_data(rx_fifo_data), .rx_block_bytes(rx_block_bytes),
    .rx_block_ready(rx_block_ready), .rx_fifo_rd(rx_rd));
  hbd_host_model u_host (.ref_clk(ref_clk), .ack_pin_n(ack_pin_n), .data_out(data_out),
    .chip_sel_n(cs_n), .dma_grant_n(gnt_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
    .data_in(data_in), .hangs(hangs));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task finish_test;
    begin
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    u_host.access(1'b0, 1'b0, a, {8'h00, d}, q);
  endtask
  task rdchk(input [7:0] a, input [7:0] e, input [8*10:1] n);
    begin
      u_host.access(1'b0, 1'b1, a, 16'h0000, q);
      `CHK(n, e, q[7:0])
    end
  endtask
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      miscompares = miscompares + 1;
      finish_test;
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (12) @(posedge ref_clk);
    `CHK("oe_rst", 5'h00, {ack_oe, irq_oe, data_oe, tx_oe, rx_oe})
    reset_n <= 1'b1;
    for (i = 0; i < 3; i = i + 1)
    begin
      rdchk(`HBD_ADR_IMSK0 + i[7:0], `HBD_MASK_RST, "mask_rst");
      irq_events <= 24'h000001 << (8 * i);
      @(posedge ref_clk);
      irq_events <= 24'h000000;
      repeat (2) @(posedge ref_clk);
      `CHK("irq_masked", 1'b1, irq_pin_n)
      wr(`HBD_ADR_IMSK0 + i[7:0], 8'hFE);
      repeat (2) @(posedge ref_clk);
      `CHK("irq_on", 1'b0, irq_pin_n)
      rdchk(`HBD_ADR_IST0 + i[7:0], 8'h01, "status");
      repeat (2) @(posedge ref_clk);
      `CHK("irq_off", 1'b1, irq_pin_n)
    end
    wr(8'h30, 8'h5A);
    rdchk(8'h30, 8'h00, "unmapped");
    // A long count pauses after one block and resumes for its rest; a short one ends early
    for (j = 0; j < 3; j = j + 1)
    begin
      if (j != 1)
      begin
        wr(`HBD_ADR_TXCNT_LO, j ? 8'h03 : 8'h22);
        wr(`HBD_ADR_TXCNT_HI, 8'h00);
      end
      tx_dma_start <= 1'b1;
      @(posedge ref_clk);
      tx_dma_start <= 1'b0;
      for (i = 0; i < (j == 0 ? 32 : j + 1); i = i + 1)
      begin
        @(posedge ref_clk);
        `CHK("tx_req", 1'b1, tx_req)
        u_host.access(1'b1, 1'b0, `HBD_ADR_IMSK0, {8'h00, 8'hC0 + i[7:0]}, q);
      end
      repeat (2) @(posedge ref_clk);
      `CHK("tx_req_end", 1'b0, tx_req)
      `CHK("tx_data", 8'hC0 + i[7:0] - 8'h01, tx_data[7:0])
    end
    rdchk(`HBD_ADR_IMSK0, 8'hFE, "dma_no_reg");
    rx_block_ready <= 1'b1;
    @(posedge ref_clk);
    rx_block_ready <= 1'b0;
    for (i = 0; i < 2; i = i + 1)
    begin
      rx_fifo_data <= 16'h00A0 + i[15:0];
      @(posedge ref_clk);
      `CHK("rx_req", 1'b1, rx_req)
      u_host.access(1'b1, 1'b1, 8'h30, 16'h0000, q);
      `CHK("rx_data", 8'hA0 + i[7:0], q[7:0])
    end
    repeat (2) @(posedge ref_clk);
    `CHK("rx_req_end", 1'b0, rx_req)
    // Word and high-lane transfers on the 16-bit bus
    width16 <= 1'b1;
    lane_en_n <= 2'b00;
    u_host.access(1'b0, 1'b0, `HBD_ADR_TXCNT_LO, 16'h1234, q);
    rdchk(`HBD_ADR_TXCNT_HI, 8'h12, "word_hi");
    lane_en_n <= 2'b01;
    u_host.access(1'b0, 1'b1, `HBD_ADR_TXCNT_LO, 16'h0000, q);
    `CHK("hi_lane", 16'h3400, q)
    width16 <= 1'b0;
    lane_en_n <= 2'b10;
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    rdchk(`HBD_ADR_IMSK0, `HBD_MASK_RST, "mask_rst2");
    // Static high: single strobe; the write leaves the status address on the data lines
    style <= 1'b1;
    rdchk(`HBD_ADR_IMSK0, `HBD_MASK_RST, "single");
    u_host.access(1'b0, 1'b0, 8'h30, ~{8'h00, `HBD_ADR_STAT}, q);
    style <= 1'b0;
    rdchk(8'h30, 8'h04, "muxed");
    `CHK("hangs", 8'h00, hangs)
    finish_test;
  end
endmodule // tb_top
